// ==== rtl/mcrc_top.sv ====
// current regulation control with classic wishbone register slave
`include "mcrc_consts.svh"
module mcrc_top
  import mcrc_pkg::*;
#(
  parameter int OFF_CYC = `MCRC_OFF_CYC, // off_time in cycles
  parameter int BLANK_CYC = `MCRC_BLANK_CYC, // comparator_blank_time
  parameter int DEG_CYC = `MCRC_DEG_CYC // comparator_filter_time
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [3:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic bridge_input1_pin_i, // control pin 1, async
  input wire logic bridge_input2_pin_i, // control pin 2, async
  input wire logic sleep_i, // sleep request, async
  input wire logic cmp_ext_i, // sense above external ref, async
  input wire logic cmp_int_i, // sense above 500 mV ref, async
  input wire logic inrush_window_i, // inrush_window active
  output mcrc_bridge_t bridge_o, // gate drives
  output logic fault_indicator_n_o, // open-drain level, always 0
  output logic fault_indicator_n_oe_o // high while pulling low
);
  localparam int OW = $clog2(OFF_CYC + 1); // off counter width
  localparam int BW = $clog2(BLANK_CYC + 1); // blank counter width
  localparam int DW = $clog2(DEG_CYC + 1); // filter counter width

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [4:0] meta_q; // first stage, read only by second stage
  logic [4:0] sync_q; // second stage
  logic [4:0] sync_d; // next value of the second stage
  always_comb
  begin
    sync_d = meta_q;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
    end
    else
    begin
      meta_q <= {cmp_int_i, cmp_ext_i, sleep_i, bridge_input2_pin_i,
                 bridge_input1_pin_i};
      sync_q <= sync_d;
    end
  end

  // ************************************************************
  // register file and wishbone slave
  // ************************************************************
  mcrc_ctrl_t ctrl_q, ctrl_d; // software control
  logic ack_q, ack_d; // one-cycle acknowledge
  logic [31:0] rdat_q, rdat_d; // read data
  logic [31:0] status; // live status word
  mcrc_state_t state_q, state_d; // regulation state
  logic trip; // filtered trip
  logic report_q, report_d; // regulation report active
  // answer one cycle after the request, drop ack the cycle after
  always_comb
  begin
    ctrl_d = ctrl_q;
    ack_d = cyc_i && stb_i && !ack_q;
    rdat_d = rdat_q;
    status = 32'h0000_0000;
    status[`MCRC_S_BRAKE] = (state_q != MCRC_IDLE);
    status[`MCRC_S_REPORT] = report_q;
    status[`MCRC_S_TRIP] = trip;
    status[`MCRC_S_INRUSH] = inrush_window_i;
    status[`MCRC_S_STATE +: 2] = state_q;
    if (ack_d)
    begin
      unique case (adr_i)
        `MCRC_ADR_CTRL:
        begin
          rdat_d = {22'h000000, ctrl_q};
          if (we_i && sel_i[0])
            ctrl_d[7:0] = dat_i[7:0];
          if (we_i && sel_i[1])
            ctrl_d[9:8] = dat_i[9:8];
        end
        `MCRC_ADR_STATUS:
          rdat_d = status; // writes ignored
        default:
          rdat_d = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= mcrc_ctrl_t'(`MCRC_CTRL_RST);
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // ************************************************************
  // command decode and comparator filtering
  // ************************************************************
  logic in1, in2; // selected control inputs
  logic cmp; // selected comparator
  logic drive_cmd; // forward or reverse commanded
  logic in_chg; // any change of either input
  logic cbc_edge; // edge that ends a held brake
  logic reg_en; // current regulation allowed now
  logic [1:0] prev_q, prev_d; // last selected inputs
  logic [1:0] pin_q, pin_d; // last pin levels
  logic [1:0] bit_q, bit_d; // last register bit levels
  logic [BW-1:0] blank_q, blank_d; // blanking counter
  logic [DW-1:0] deg_q, deg_d; // filter counter
  mcrc_bridge_t out_q, out_d; // gate drives
  always_comb
  begin
    in1 = ctrl_q.src ? ctrl_q.in1_bit : sync_q[0];
    in2 = ctrl_q.src ? ctrl_q.in2_bit : sync_q[1];
    cmp = ctrl_q.int_ref ? sync_q[4] : sync_q[3];
    drive_cmd = in1 ^ in2;
    prev_d = {in2, in1};
    pin_d = sync_q[1:0];
    bit_d = {ctrl_q.in2_bit, ctrl_q.in1_bit};
    in_chg = (prev_d != prev_q);
    cbc_edge = ctrl_q.src ? |(bit_d & ~bit_q) : (pin_d != pin_q);
    unique case (ctrl_q.mode)
      2'b00: reg_en = 1'b0;
      2'b01: reg_en = ctrl_q.stall_en ? inrush_window_i : 1'b1;
      default: reg_en = 1'b1;
    endcase
    // restart blanking on every output switch
    if (out_d != out_q)
      blank_d = BW'(BLANK_CYC);
    else if (blank_q != '0)
      blank_d = blank_q - BW'(1);
    else
      blank_d = blank_q;
    if (!cmp || blank_q != '0 || out_d != out_q)
      deg_d = '0;
    else if (deg_q != DW'(DEG_CYC))
      deg_d = deg_q + DW'(1);
    else
      deg_d = deg_q;
  end
  assign trip = (deg_q == DW'(DEG_CYC));

  // ************************************************************
  // regulation state machine and outputs
  // ************************************************************
  logic [OW-1:0] off_q, off_d; // off-time counter
  always_comb
  begin
    state_d = state_q;
    off_d = (off_q != '0) ? off_q - OW'(1) : off_q;
    unique case (state_q)
      MCRC_IDLE:
      begin
        // only schemes 00 and 01 limit current
        if (trip && reg_en && drive_cmd && !ctrl_q.scheme[1])
        begin
          if (ctrl_q.scheme[0])
            state_d = MCRC_HOLD;
          else
          begin
            state_d = MCRC_OFF;
            off_d = OW'(OFF_CYC - 1);
          end
        end
      end
      MCRC_OFF:
      begin
        if (in_chg)
          state_d = MCRC_IDLE;
        else if (off_q == '0)
        begin
          if (cmp)
            off_d = OW'(OFF_CYC - 1);
          else
            state_d = MCRC_IDLE;
        end
      end
      MCRC_HOLD:
      begin
        if (cbc_edge || ctrl_q.scheme != 2'b01)
          state_d = MCRC_IDLE;
      end
      default:
        state_d = MCRC_IDLE;
    endcase
    // truth table, sleep forces high impedance
    if (sync_q[2])
      out_d = 4'b0000;
    else if (state_d != MCRC_IDLE)
      out_d = 4'b0101;
    else
    begin
      unique case ({in1, in2})
        2'b00: out_d = 4'b0000;
        2'b01: out_d = 4'b0110;
        2'b10: out_d = 4'b1001;
        default: out_d = 4'b0101;
      endcase
    end
    // report in held brake with drive command
    report_d = ctrl_q.report && state_d == MCRC_HOLD && drive_cmd;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= MCRC_IDLE;
      off_q <= '0;
      out_q <= 4'b0000;
      report_q <= 1'b0;
      prev_q <= 2'b00;
      pin_q <= 2'b00;
      bit_q <= 2'b00;
      blank_q <= '0;
      deg_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      off_q <= off_d;
      out_q <= out_d;
      report_q <= report_d;
      prev_q <= prev_d;
      pin_q <= pin_d;
      bit_q <= bit_d;
      blank_q <= blank_d;
      deg_q <= deg_d;
    end
  end
  assign bridge_o = out_q;
  assign fault_indicator_n_oe_o = report_q;
  assign fault_indicator_n_o = 1'b0;

  // ************************************************************
  // assertions and covers
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // the drive register lags sleep by one cycle, so look at last sleep
  chk_off_brake: assert property (state_q == MCRC_OFF &&
    !$past(sync_q[2]) |-> out_q == 4'b0101)
    else $error("off-time not braking");
  chk_hold_exit: assert property (state_q == MCRC_HOLD &&
    cbc_edge |=> state_q == MCRC_IDLE) else $error("hold kept");
  chk_off_cancel: assert property (state_q == MCRC_OFF &&
    in_chg |=> state_q == MCRC_IDLE) else $error("off not cancelled");
  chk_mode_zero: assert property (ctrl_q.mode == 2'b00 &&
    state_q == MCRC_IDLE |=> state_q == MCRC_IDLE)
    else $error("regulated in mode 00");
  chk_blank_mask: assert property (blank_q != '0 |-> deg_q == '0)
    else $error("filter ran while blanked");
  chk_deg_source: assert property (deg_q != '0 |-> $past(cmp))
    else $error("filter ran without comparator");
  chk_off_auto: assert property (state_q == MCRC_OFF &&
    off_q == '0 && !in_chg && !cmp |=> state_q == MCRC_IDLE)
    else $error("off-time not ended");
  // the report flop holds the command of the cycle before
  chk_report_cause: assert property (fault_indicator_n_oe_o |->
    $past(ctrl_q.report) && state_q == MCRC_HOLD && $past(drive_cmd))
    else $error("bad report");
  chk_scheme_cbc: assert property (state_q == MCRC_IDLE && trip &&
    reg_en && drive_cmd && ctrl_q.scheme == 2'b01
    |=> state_q == MCRC_HOLD) else $error("no hold");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  cov_off: cover property (state_q == MCRC_IDLE ##1 state_q == MCRC_OFF);
  cov_hold: cover property (state_q == MCRC_IDLE ##1 state_q == MCRC_HOLD);
  cov_rebrake: cover property (state_q == MCRC_OFF && off_q == '0 && cmp);
  cov_report: cover property ($rose(fault_indicator_n_oe_o));
endmodule // mcrc_top

// ==== rtl/mcrc_consts.svh ====
// constants of the motor current regulation control block
`ifndef MCRC_CONSTS_SVH
`define MCRC_CONSTS_SVH
// ************************************************************
// register map, byte addresses
// ************************************************************
`define MCRC_ADR_CTRL 4'h0
`define MCRC_ADR_STATUS 4'h4
`define MCRC_CTRL_RST 10'h000
// ctrl field positions
`define MCRC_F_SCHEME 0
`define MCRC_F_MODE 2
`define MCRC_F_STALL_EN 4
`define MCRC_F_INT_REF 5
`define MCRC_F_REPORT 6
`define MCRC_F_SRC 7
`define MCRC_F_IN1_BIT 8
`define MCRC_F_IN2_BIT 9
// status field positions
`define MCRC_S_BRAKE 0
`define MCRC_S_REPORT 1
`define MCRC_S_TRIP 2
`define MCRC_S_INRUSH 3
`define MCRC_S_STATE 4
// ************************************************************
// default durations in cycles of the 200 MHz clock
// ************************************************************
`define MCRC_OFF_CYC 200
`define MCRC_BLANK_CYC 20
`define MCRC_DEG_CYC 8
`endif

// ==== rtl/mcrc_pkg.sv ====
// types of the motor current regulation control block
package mcrc_pkg;
  // control register layout, low bit first at the bottom
  typedef struct packed {
    logic in2_bit; // bridge_input2_bit
    logic in1_bit; // bridge_input1_bit
    logic src; // bridge_control_source
    logic report; // per_cycle_limit_report
    logic int_ref; // internal threshold select
    logic stall_en; // stall detection enable
    logic [1:0] mode; // regulation_enable_mode
    logic [1:0] scheme; // regulation scheme select
  } mcrc_ctrl_t;
  // gate drives of the two half bridges
  typedef struct packed {
    logic hs1; // out1 high side
    logic ls1; // out1 low side
    logic hs2; // out2 high side
    logic ls2; // out2 low side
  } mcrc_bridge_t;
  // regulation state
  typedef enum logic [1:0] {
    MCRC_IDLE = 2'b00,
    MCRC_OFF = 2'b01,
    MCRC_HOLD = 2'b10
  } mcrc_state_t;
endpackage

// ==== test/mcrc_load_model.sv ====
// stalled motor winding and current comparator seen by the block
module mcrc_load_model
  import mcrc_pkg::*;
#(
  parameter int EXT_LVL = 6, // level of the external reference
  parameter int INT_LVL = 10 // level of the fixed internal reference
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset
  input wire mcrc_bridge_t bridge_i, // gate drives from the block
  input wire logic load_i, // high while the rotor is blocked
  input wire logic stuck_i, // high while the current cannot decay
  output logic cmp_ext_o, // sense at or above external reference
  output logic cmp_int_o // sense at or above internal reference
);
  logic [3:0] lvl_q; // winding current level
  logic [3:0] lvl_d; // next current level
  logic on; // a high side conducts
  // current builds under drive, decays in brake or coast unless stuck
  always_comb
  begin
    on = bridge_i.hs1 | bridge_i.hs2;
    lvl_d = lvl_q;
    if (!load_i)
      lvl_d = 4'h0; // free rotor, no stall current
    else if (on && lvl_q != 4'hf)
      lvl_d = lvl_q + 4'h1;
    else if (!on && !stuck_i && lvl_q != 4'h0)
      lvl_d = lvl_q - 4'h1;
  end
  // comparators registered: they lag the current by a cycle
  always_ff @(posedge clk_i)
  begin
    lvl_q <= rst_i ? 4'h0 : lvl_d;
    cmp_ext_o <= !rst_i && (32'(lvl_q) >= EXT_LVL);
    cmp_int_o <= !rst_i && (32'(lvl_q) >= INT_LVL);
  end
endmodule // mcrc_load_model

// ==== test/tb_motor_current_regulation_ctrl.sv ====
// self-checking bench of the current regulation control block
module tb_motor_current_regulation_ctrl
  import mcrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OFF = 40; // off_time, shortened
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o, seed = 32'h68cb;
  logic pin1 = 1'b0, pin2 = 1'b0, sleep = 1'b0, inrush = 1'b0;
  logic load = 1'b0, stuck = 1'b0, cmp_ext, cmp_int, fault_n, fault_oe;
  mcrc_bridge_t bridge;
  int fail_count = 0, num_checks = 0, cycles = 0, brk_cnt = 0, base;
  // regulation table: {expect, inrush, stall, mode, scheme}
  logic [6:0] tbl [9] = '{7'b0100000, 7'b0010100, 7'b1110100,
    7'b1000100, 7'b1011000, 7'b1001100, 7'b0001010, 7'b0001011,
    7'b1001001};
  always #2.5 clk_i = ~clk_i;
  mcrc_top #(.OFF_CYC(OFF), .BLANK_CYC(3), .DEG_CYC(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
    .bridge_input1_pin_i(pin1), .bridge_input2_pin_i(pin2),
    .sleep_i(sleep), .cmp_ext_i(cmp_ext), .cmp_int_i(cmp_int),
    .inrush_window_i(inrush), .bridge_o(bridge),
    .fault_indicator_n_o(fault_n), .fault_indicator_n_oe_o(fault_oe));
  mcrc_load_model u_load (.clk_i(clk_i), .rst_i(rst_i),
    .bridge_i(bridge), .load_i(load), .stuck_i(stuck), .cmp_ext_o(cmp_ext),
    .cmp_int_o(cmp_int));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // outputs commanded by {in1, in2}
  function automatic mcrc_bridge_t drive(input logic [1:0] v);
    case (v)
      2'b01: return mcrc_bridge_t'(4'b0110);
      2'b10: return mcrc_bridge_t'(4'b1001);
      2'b11: return mcrc_bridge_t'(4'b0101);
      default: return mcrc_bridge_t'(4'b0000);
    endcase
  endfunction
  task automatic cmp_word(input string n, input logic [31:0] e, a);
    num_checks++;
    if (a !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic cmp_br(input string n, input mcrc_bridge_t e, a);
    num_checks++;
    if (a !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", n, e, a);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no cycle count assumed: only the bench timeout ends this wait
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] v);
    @(posedge clk_i);
    pin1 <= v[1];
    pin2 <= v[0];
  endtask
  // bounded wait: the block may take a few cycles through its syncs
  task automatic expect_br(input string n, input mcrc_bridge_t e, int lim);
    int k;
    k = 0;
    while (bridge !== e && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    cmp_br(n, e, bridge);
  endtask
  // coast with free rotor so the current falls to zero
  task automatic settle(input logic inr);
    pins(2'b00);
    load <= 1'b0;
    stuck <= 1'b0;
    inrush <= inr;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // brake cycle count and hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (bridge === mcrc_bridge_t'(4'b0101))
      brk_cnt <= brk_cnt + 1;
    if (cycles == 12000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    cmp_word("ctrl reset", 32'h0, rdat);
    wb(1'b1, 4'h0, 32'hffffffff);
    wb(1'b0, 4'h0, 32'h0);
    cmp_word("ctrl width", 32'h3ff, rdat);
    wb(1'b1, 4'h8, 32'hffffffff);
    wb(1'b0, 4'h8, 32'h0);
    cmp_word("unmapped", 32'h0, rdat);
    $display("test registers done");
    foreach (tbl[i])
    begin
      settle(tbl[i][5]);
      wb(1'b1, 4'h0, {27'h0, tbl[i][4:0]});
      pins(2'b10);
      load <= 1'b1;
      // counted from here so a brake left from the last setting is unseen
      base = brk_cnt;
      repeat (100) @(posedge clk_i);
      cmp_word("regulated", 32'(tbl[i][6]), 32'(brk_cnt != base));
    end
    $display("test enable modes done");
    settle(1'b0);
    wb(1'b1, 4'h0, 32'h28);
    pins(2'b10);
    load <= 1'b1;
    // the external level would already have tripped by now
    repeat (17) @(posedge clk_i);
    cmp_br("internal ref", 4'b1001, bridge);
    expect_br("trip brake", 4'b0101, 60);
    base = cycles;
    expect_br("restore", 4'b1001, OFF + 20);
    cmp_word("off cycles", OFF, cycles - base);
    expect_br("rebrake", 4'b0101, 60);
    // current kept above the trip level: the off-time must renew
    stuck <= 1'b1;
    repeat (OFF + 2) @(posedge clk_i);
    cmp_br("brake renewed", 4'b0101, bridge);
    pins(2'b01);
    expect_br("cancel", 4'b0110, 6);
    $display("test fixed off-time done");
    settle(1'b0);
    wb(1'b1, 4'h0, 32'h49);
    pins(2'b10);
    load <= 1'b1;
    expect_br("cbc brake", 4'b0101, 60);
    repeat (OFF + 10) @(posedge clk_i);
    cmp_br("cbc hold", 4'b0101, bridge);
    cmp_word("report on", 32'h1, 32'(fault_oe));
    cmp_word("fault level", 32'h0, 32'(fault_n));
    wb(1'b0, 4'h4, 32'h0);
    cmp_word("status hold", 32'h23, rdat & 32'h33);
    pins(2'b01); // the controller ends the brake with an edge
    expect_br("cbc release", 4'b0110, 6);
    cmp_word("report off", 32'h0, 32'(fault_oe));
    settle(1'b0);
    wb(1'b1, 4'h0, 32'h1c9);
    load <= 1'b1;
    expect_br("bit brake", 4'b0101, 60);
    wb(1'b1, 4'h0, 32'h2c9);
    expect_br("bit release", 4'b0110, 6);
    $display("test cycle-by-cycle done");
    settle(1'b0);
    wb(1'b1, 4'h0, 32'h0);
    repeat (24)
    begin
      seed = xs(seed);
      pins(seed[1:0]);
      sleep <= seed[2];
      repeat (6) @(posedge clk_i);
      cmp_br("decode", seed[2] ? 4'b0000 : drive(seed[1:0]), bridge);
    end
    $display("test decode done");
    finish_test();
  end
endmodule // tb_motor_current_regulation_ctrl
